// File: common/probe_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the serial probe monitor. Assumes inclusion by bare name.
`ifndef PROBE_DEFS_SVH
`define PROBE_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_MONITOR_CTRL 16'h2106
`define IDX_PROBE0_HIGH 16'h210d
`define IDX_PROBE0_LOW 16'h210e
`define IDX_PROBE1 16'h210f
`define IDX_PROBE2 16'h2110
`define IDX_PROBE3 16'h2111
`define IDX_MONITOR_STATUS 16'h2112

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MONITOR_ENABLE_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_OVERRUN_BIT 1
`define STAT_COUNT_LSB 8

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RST_ENABLE 1'h0
`define RST_PROBE0 10'h000
`define RST_PROBE 8'h00
`define PROBE_BITS 10
`define PROBE_COUNT 4
`define CE_DIV_DEFAULT 4

`endif

// File: common/probe_pkg.sv
// Types shared by the probe monitor modules.
// Assumes the defs header supplies all numeric constants.
package probe_pkg;

    // Serial output sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } mon_state_e;

    // One probe as shifted on the pin
    typedef logic [9:0] probe_t;

endpackage

// File: logic/ce_tick_divider.sv
// Divides the system clock into one-cycle compute-engine bit ticks.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/1ps

module ce_tick_divider #(
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    output logic tick
);

    // ----------------------------------------------------------------
    // Divider counter
    // ----------------------------------------------------------------
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    generate
        if (DIV < 1) begin : g_bad_div
            $error("ce_tick_divider: DIV must be at least 1");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    wire at_end = (cnt_r == CW'(DIV - 1));

    // Restart realigns the phase so every bit lasts exactly DIV cycles
    always_ff @(posedge clk) begin
        if (rst || restart || at_end) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    assign tick = at_end && !restart;

endmodule

// File: logic/probe_shifter.sv
// Parallel-in serial-out shifter, most significant bit first.
// Assumes load and abort never coincide with a caller expecting both.
`timescale 1ns/1ps

module probe_shifter #(
    parameter int WIDTH = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_data,
    input wire logic bit_en,
    input wire logic abort,
    output logic serial_bit,
    output logic busy,
    output logic [7:0] bits_left
);

    // ----------------------------------------------------------------
    // Shift register and bit counter
    // ----------------------------------------------------------------
    generate
        if (WIDTH < 1 || WIDTH > 255) begin : g_bad_width
            $error("probe_shifter: WIDTH must be 1 to 255");
        end
    endgenerate

    logic [WIDTH-1:0] sh_r;
    logic [7:0] left_r;

    // Abort wins so a disabled monitor never emits a stale bit
    always_ff @(posedge clk) begin
        if (rst || abort) begin
            sh_r <= '0;
            left_r <= 8'h00;
        end else if (load) begin
            sh_r <= load_data;
            left_r <= 8'(WIDTH);
        end else if (bit_en && left_r != 8'h00) begin
            sh_r <= {sh_r[WIDTH-2:0], 1'b0};
            left_r <= left_r - 8'h01;
        end
    end

    assign serial_bit = sh_r[WIDTH-1];
    assign busy = (left_r != 8'h00);
    assign bits_left = left_r;

endmodule

// File: logic/realtime_probe_monitor.sv
// Serial probe monitor: APB registers, pass-triggered probe stream.
// Assumes pass_start is a one-cycle pulse from the compute engine,
// on clk, and that the monitor pin goes straight to a device pad.
// Passes arriving mid-stream are dropped and flagged.
//
// How it works
// R1 - Enable cleared holds monitor pin low
// R2 - Enabled: four probes shifted before each pass; the code shifts them after each pass_start
// R3 - Probe registers ignored while enable is zero
// R4 - Probe zero ten bits, high two separate
// R5 - Other probes eight bits, zero-extended to ten
// R6 - Order zero to three, MSB first, one per tick
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "probe_defs.svh"

module realtime_probe_monitor #(
    parameter int CE_DIV = `CE_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pass_start,
    output logic serial_monitor_pin
);

    // ----------------------------------------------------------------
    // Sizes and checks
    // ----------------------------------------------------------------
    localparam int STREAM_BITS = `PROBE_BITS * `PROBE_COUNT;

    generate
        if (CE_DIV < 1) begin : g_bad_div
            $error("realtime_probe_monitor: CE_DIV must be at least 1");
        end
        if (STREAM_BITS > 255) begin : g_bad_stream
            $error("realtime_probe_monitor: stream too long for the bit counter");
        end
    endgenerate

    // Byte address of a register index
    function automatic logic [15:0] reg_addr(input logic [15:0] idx);
        reg_addr = {idx[13:0], 2'b00};
    endfunction

    // Widen one probe byte to the ten-bit shifted form
    function automatic probe_pkg::probe_t widen(input logic [7:0] b);
        widen = {2'b00, b};
    endfunction

    // Read word of a byte register; upper bits read zero
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h0, b};
    endfunction

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic monitor_enable_r;
    logic [1:0] probe0_high_r;
    logic [7:0] probe0_low_r;
    logic [7:0] probe1_r;
    logic [7:0] probe2_r;
    logic [7:0] probe3_r;
    logic overrun_r;
    logic [15:0] pass_count_r;
    logic [31:0] prdata_r;

    // Address decode on the held APB address
    wire hit_ctrl = (paddr == reg_addr(`IDX_MONITOR_CTRL));
    wire hit_p0h = (paddr == reg_addr(`IDX_PROBE0_HIGH));
    wire hit_p0l = (paddr == reg_addr(`IDX_PROBE0_LOW));
    wire hit_p1 = (paddr == reg_addr(`IDX_PROBE1));
    wire hit_p2 = (paddr == reg_addr(`IDX_PROBE2));
    wire hit_p3 = (paddr == reg_addr(`IDX_PROBE3));
    wire hit_stat = (paddr == reg_addr(`IDX_MONITOR_STATUS));
    wire hit_any = hit_ctrl | hit_p0h | hit_p0l | hit_p1 | hit_p2 | hit_p3 | hit_stat;

    // Phases of a transfer; zero wait states
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire wr_lane0 = access_ph && pwrite && pstrb[0] && hit_any;
    wire wr_ctrl = wr_lane0 && hit_ctrl;
    wire wr_stat = wr_lane0 && hit_stat;

    assign pready = access_ph;
    assign pslverr = access_ph && !hit_any;

    // ----------------------------------------------------------------
    // Sequencer signals
    // ----------------------------------------------------------------
    probe_pkg::mon_state_e state_r;
    probe_pkg::mon_state_e state_nxt;
    logic sh_bit;
    logic sh_busy;
    logic [7:0] sh_left;
    logic ce_tick;
    logic pin_r;

    // A pass is served only when enabled and no stream is under way
    wire start_ok = pass_start && monitor_enable_r && (state_r == probe_pkg::ST_IDLE);
    wire pass_lost = pass_start && monitor_enable_r && (state_r == probe_pkg::ST_SHIFT);
    wire abort = !monitor_enable_r; // R3

    // Stream ends on the tick that moves the last bit out
    wire last_tick = ce_tick && (sh_left == 8'h01);

    // Snapshot order: probe zero first, each MSB first
    wire [STREAM_BITS-1:0] stream_word = {probe0_high_r, probe0_low_r,
        widen(probe1_r), widen(probe2_r), widen(probe3_r)}; // R4 R5 R6

    // ----------------------------------------------------------------
    // Register writes; only byte lane 0 carries data
    // ----------------------------------------------------------------
    // One write strobe per register
    wire wr_p0h = wr_lane0 && hit_p0h;
    wire wr_p0l = wr_lane0 && hit_p0l;
    wire wr_p1 = wr_lane0 && hit_p1;
    wire wr_p2 = wr_lane0 && hit_p2;
    wire wr_p3 = wr_lane0 && hit_p3;

    // Enable; clearing it aborts a stream at once
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor_enable_r <= `RST_ENABLE;
        end else if (wr_ctrl) begin
            monitor_enable_r <= pwdata[`MONITOR_ENABLE_BIT]; // R1 R3
        end
    end

    // Probe zero, upper two bits in their own word
    always_ff @(posedge clk) begin
        if (rst) begin
            probe0_high_r <= 2'(`RST_PROBE0 >> 8);
        end else if (wr_p0h) begin
            probe0_high_r <= pwdata[1:0]; // R4
        end
    end

    // Probe zero, low byte
    always_ff @(posedge clk) begin
        if (rst) begin
            probe0_low_r <= `RST_PROBE;
        end else if (wr_p0l) begin
            probe0_low_r <= pwdata[7:0]; // R4
        end
    end

    // Probe one; its top two stream bits are fixed zero
    always_ff @(posedge clk) begin
        if (rst) begin
            probe1_r <= `RST_PROBE;
        end else if (wr_p1) begin
            probe1_r <= pwdata[7:0]; // R5
        end
    end

    // Probe two
    always_ff @(posedge clk) begin
        if (rst) begin
            probe2_r <= `RST_PROBE;
        end else if (wr_p2) begin
            probe2_r <= pwdata[7:0]; // R5
        end
    end

    // Probe three
    always_ff @(posedge clk) begin
        if (rst) begin
            probe3_r <= `RST_PROBE;
        end else if (wr_p3) begin
            probe3_r <= pwdata[7:0]; // R5
        end
    end

    // ----------------------------------------------------------------
    // Pass bookkeeping
    // ----------------------------------------------------------------
    // Overrun is sticky, write one to clear; a new loss wins the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            overrun_r <= 1'b0;
        end else if (pass_lost) begin
            overrun_r <= 1'b1;
        end else if (wr_stat && pwdata[`STAT_OVERRUN_BIT]) begin
            overrun_r <= 1'b0;
        end
    end

    // Passes actually streamed, wraps; handy for bench correlation
    always_ff @(posedge clk) begin
        if (rst) begin
            pass_count_r <= 16'h0000;
        end else if (start_ok) begin
            pass_count_r <= pass_count_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Read data, registered in the setup cycle
    // ----------------------------------------------------------------
    wire [31:0] rd_ctrl = {30'h0, monitor_enable_r, 1'b0};
    wire [31:0] rd_stat = {pass_count_r, sh_left, 6'h00, overrun_r, sh_busy};

    // One word per register, upper bits zero
    wire [31:0] rd_p0h = {30'h0, probe0_high_r};
    wire [31:0] rd_p0l = byte_word(probe0_low_r);
    wire [31:0] rd_p1 = byte_word(probe1_r);
    wire [31:0] rd_p2 = byte_word(probe2_r);
    wire [31:0] rd_p3 = byte_word(probe3_r);

    // Selection by address; unmapped reads zero
    wire [31:0] rd_mux =
        hit_ctrl ? rd_ctrl :
        hit_p0h ? rd_p0h :
        hit_p0l ? rd_p0l :
        hit_p1 ? rd_p1 :
        hit_p2 ? rd_p2 :
        hit_p3 ? rd_p3 :
        hit_stat ? rd_stat : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= 32'h0;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            probe_pkg::ST_IDLE: begin
                if (start_ok) state_nxt = probe_pkg::ST_SHIFT; // R2
            end
            probe_pkg::ST_SHIFT: begin
                if (abort || last_tick) begin
                    state_nxt = probe_pkg::ST_IDLE;
                end
            end
            default: state_nxt = probe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= probe_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Bit timing and shifting
    // ----------------------------------------------------------------
    ce_tick_divider #(
        .DIV(CE_DIV)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .restart(start_ok),
        .tick(ce_tick)
    );

    probe_shifter #(
        .WIDTH(STREAM_BITS)
    ) u_shift (
        .clk(clk),
        .rst(rst),
        .load(start_ok),
        .load_data(stream_word),
        .bit_en(ce_tick), // R6
        .abort(abort),
        .serial_bit(sh_bit),
        .busy(sh_busy),
        .bits_left(sh_left)
    );

    // ----------------------------------------------------------------
    // Monitor pin
    // ----------------------------------------------------------------
    // Pin from a flop so the pad sees no decode glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= monitor_enable_r && sh_busy && sh_bit; // R1 R2
        end
    end

    assign serial_monitor_pin = pin_r;

endmodule

// File: tb/probe_monitor_assertions.sv
// Checker for the probe monitor, bound to its top module.
// Assumes aligned APB addresses and one-cycle pass_start pulses.
`timescale 1ns/1ps
`include "probe_defs.svh"

module probe_monitor_assertions #(
    parameter int CE_DIV = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pass_start,
    input wire logic serial_monitor_pin
);
    localparam int T1 = 2;
    localparam int T2 = 2 + CE_DIV;
    localparam int TH = 1 + CE_DIV;
    localparam int TP = 2 + 10 * CE_DIV;
    localparam int TE = 2 + 40 * CE_DIV;
    localparam int TB = 40 * CE_DIV;
    logic en_r;
    logic [9:0] p0_r;
    int cnt_r;
    wire wr = psel && penable && pwrite && pstrb[0];
    wire start = pass_start && en_r && cnt_r == 0;

    // Shadow copies; counter spans the busy time and is cleared by disable
    always_ff @(posedge clk) begin
        if (rst) begin
            en_r <= 1'b0;
            p0_r <= 10'h000;
            cnt_r <= 0;
        end else begin
            if (wr && paddr[15:2] == `IDX_MONITOR_CTRL)
                en_r <= pwdata[1];
            if (wr && paddr[15:2] == `IDX_PROBE0_HIGH)
                p0_r[9:8] <= pwdata[1:0];
            if (wr && paddr[15:2] == `IDX_PROBE0_LOW)
                p0_r[7:0] <= pwdata[7:0];
            cnt_r <= start ? TB : ((cnt_r > 0 && en_r) ? cnt_r - 1 : 0);
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // ----
    // Properties
    // ----
    property p_low; !en_r [*2] |-> !serial_monitor_pin; endproperty
    a_low: assert property (p_low) else $error("pin high while disabled");
    property p_ign; pass_start && !en_r |-> ##3 !serial_monitor_pin; endproperty
    a_ign: assert property (p_ign) else $error("pass started while disabled");
    property p_first; start |-> ##T1 serial_monitor_pin == p0_r[9]; endproperty
    a_first: assert property (p_first) else $error("first bit wrong");
    property p_second; start |-> ##T2 serial_monitor_pin == p0_r[8]; endproperty
    a_second: assert property (p_second) else $error("second bit wrong");
    property p_pad; start |-> ##TP !serial_monitor_pin; endproperty
    a_pad: assert property (p_pad) else $error("pad bit not zero");
    property p_end; start |-> ##TE !serial_monitor_pin; endproperty
    a_end: assert property (p_end) else $error("pin high after burst");
    property p_hold; start |-> ##TH serial_monitor_pin == p0_r[9]; endproperty
    a_hold: assert property (p_hold) else $error("bit shorter than a tick");
    property p_ready; pready == (psel && penable); endproperty
    a_ready: assert property (p_ready) else $error("ready mismatch");
endmodule

bind realtime_probe_monitor probe_monitor_assertions #(.CE_DIV(CE_DIV)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pass_start(pass_start), .serial_monitor_pin(serial_monitor_pin));

// File: tb/probe_observer.sv
// Observation equipment: records each 40-bit burst seen on the pin.
// Assumes pass_start marks a pass; it never drives the device.
`timescale 1ns/1ps

module probe_observer #(
    parameter int CE_DIV = 4
) (
    input wire logic clk,
    input wire logic mark,
    input wire logic pin,
    output logic [39:0] frame,
    output int frames
);
    // Samples the first cycle of each bit mid-cycle; marks during a burst are missed
    initial begin
        frames = 0;
        frame = '0;
        forever begin
            @(posedge clk iff mark);
            @(posedge clk);
            @(negedge clk);
            for (int i = 0; i < 40; i++) begin
                frame[39 - i] = pin;
                repeat (CE_DIV) @(negedge clk);
            end
            frames++;
        end
    end
endmodule

// File: tb/realtime_probe_monitor_bench.sv
// Self-checking bench: APB master, pass pulses, pin observer.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`include "probe_defs.svh"

module realtime_probe_monitor_bench;
    localparam int DIV = 2;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pass_start = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, lfsr = 32'h9cf6;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, pin, err;
    logic [39:0] frame;
    logic [9:0] pv [4];
    logic [15:0] regs [6] = '{`IDX_MONITOR_CTRL, `IDX_PROBE0_HIGH, `IDX_PROBE0_LOW,
        `IDX_PROBE1, `IDX_PROBE2, `IDX_PROBE3};
    int frames, bad_count = 0, checks = 0;

    realtime_probe_monitor #(.CE_DIV(DIV)) dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pass_start(pass_start),
        .serial_monitor_pin(pin));
    probe_observer #(.CE_DIV(DIV)) obs_u (.clk(clk), .mark(pass_start), .pin(pin),
        .frame(frame), .frames(frames));

    always #4 clk = ~clk;

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] ba(input logic [15:0] i);
        return {i[13:0], 2'b00};
    endfunction
    // Upper two bits of the byte-wide probes always shift as zero
    function automatic logic [39:0] burst();
        return {pv[0], 2'b00, pv[1][7:0], 2'b00, pv[2][7:0], 2'b00, pv[3][7:0]};
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input string m);
        apb(0, a, '0, 4'h0);
        chk({8'h0, rd}, {8'h0, e}, m);
    endtask
    task automatic pulse_wait(input int twice);
        int f, n;
        f = frames;
        n = 0;
        @(posedge clk);
        pass_start <= 1;
        @(posedge clk);
        pass_start <= 0;
        if (twice != 0) begin
            @(posedge clk);
            pass_start <= 1;
            @(posedge clk);
            pass_start <= 0;
        end
        while (frames == f && n < 50 * DIV) begin
            @(posedge clk);
            n++;
        end
        if (frames == f)
            bad_count++;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 6; i++)
            rdchk(ba(regs[i]), 32'h0, "reset value");
        for (int i = 1; i < 6; i++)
            apb(1, ba(regs[i]), 32'hffffffff, 4'hf);
        rdchk(ba(`IDX_PROBE0_HIGH), 32'h3, "probe zero high field");
        rdchk(ba(`IDX_PROBE1), 32'hff, "probe one byte");
        apb(1, ba(`IDX_PROBE1), 32'h0, 4'he);
        rdchk(ba(`IDX_PROBE1), 32'hff, "write without low strobe landed");
        apb(1, 16'h8000, 32'hffffffff, 4'hf);
        rdchk(16'h8000, 32'h0, "unmapped read data");
        chk({39'h0, err}, 40'h1, "unmapped error");
        // Loaded probes but disabled: the burst must read all zero
        pulse_wait(0);
        chk(frame, 40'h0, "burst while disabled");
        apb(1, ba(`IDX_MONITOR_CTRL), 32'hffffffff, 4'hf);
        rdchk(ba(`IDX_MONITOR_CTRL), 32'h2, "enable field");
        // Corner values first, then random; third pass also tries an overrun
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 4; j++) begin
                lfsr = next(lfsr);
                pv[j] = k == 0 ? 10'h3ff : (k == 1 ? 10'h000 : lfsr[9:0]);
                apb(1, ba(regs[j + 2]), {lfsr[31:8], pv[j][7:0]}, 4'hf);
            end
            apb(1, ba(`IDX_PROBE0_HIGH), {lfsr[31:2], pv[0][9:8]}, 4'hf);
            pulse_wait(k == 2);
            chk(frame, burst(), "burst content");
            if (k == 2) begin
                rdchk(ba(`IDX_MONITOR_STATUS), 32'h00030002, "overrun flag");
                apb(1, ba(`IDX_MONITOR_STATUS), 32'h2, 4'hf);
                rdchk(ba(`IDX_MONITOR_STATUS), 32'h00030000, "overrun cleared");
            end
            repeat (8) @(posedge clk);
        end
        // Abort in mid-burst: pin must fall and stay low, status idle
        @(posedge clk);
        pass_start <= 1;
        @(posedge clk);
        pass_start <= 0;
        repeat (10) @(posedge clk);
        apb(0, ba(`IDX_MONITOR_STATUS), '0, 4'h0);
        chk({23'h0, rd[31:16], rd[0]}, {23'h0, 16'h0007, 1'b1}, "busy mid burst");
        apb(1, ba(`IDX_MONITOR_CTRL), 32'h0, 4'hf);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            chk({39'h0, pin}, 40'h0, "pin high after disable");
        end
        rdchk(ba(`IDX_MONITOR_STATUS), 32'h00070000, "idle after abort");
        end_of_test();
    end

    // Watchdog well beyond the expected run of about 860 cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule
